/* design/pas_pkg.sv */
// shared constants and state types for the arbiter strap block and its far end
package pas_pkg;

  // ----------------------------------------------------------------
  // arbiter masters
  // ----------------------------------------------------------------
  localparam int         PAS_MASTERS      = 6;
  localparam logic [2:0] PAS_IDX_ZERO     = 3'h0;
  localparam logic [2:0] PAS_IDX_ONE      = 3'h1;
  localparam logic [2:0] PAS_IDX_TWO      = 3'h2;
  localparam logic [2:0] PAS_IDX_THREE    = 3'h3;
  localparam logic [2:0] PAS_IDX_FOUR     = 3'h4;
  localparam logic [2:0] PAS_IDX_HOST     = 3'h5;

  // ----------------------------------------------------------------
  // strap levels
  // ----------------------------------------------------------------
  localparam logic PAS_STRAP_ARB_DISABLED  = 1'b0;
  localparam logic PAS_STRAP_FIFTH_GRANT   = 1'b0;
  localparam logic PAS_STRAP_MODE_BIG_END  = 1'b1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PAS_GNT_RESET    = 6'h00;
  localparam logic [2:0] PAS_OWNER_RESET  = 3'h5;
  localparam logic       PAS_PIN_IDLE     = 1'b1;
  localparam logic       PAS_OE_RESET     = 1'b0;
  localparam logic       PAS_STRAP_RESET  = 1'b1;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PAS_ARB_IDLE  = 2'b00,
    PAS_ARB_GRANT = 2'b01,
    PAS_ARB_GAP   = 2'b11
  } pas_arb_state_t;

  typedef enum logic [1:0]
  {
    PAS_FL_IDLE    = 2'b00,
    PAS_FL_REQ     = 2'b01,
    PAS_FL_RELEASE = 2'b11
  } pas_flush_state_t;

  typedef enum logic [1:0]
  {
    PAS_EXT_IDLE   = 2'b00,
    PAS_EXT_BRIDGE = 2'b01,
    PAS_EXT_DISK   = 2'b10,
    PAS_EXT_GAP    = 2'b11
  } pas_ext_state_t;

endpackage

/* design/pas_link_if.sv */
// pin-level link between the arbiter device and the board-side parties
`timescale 1ns/10ps
`default_nettype none
interface pas_link_if;

  // ----------------------------------------------------------------
  // plain pins, all active low
  // ----------------------------------------------------------------
  logic grant_out_zero_n;
  logic request_in_zero_n;
  logic grant_out_one_n;
  logic request_in_one_n;
  logic request_in_two_n;
  logic request_in_three_n;
  logic grant_four_flush_req_n;
  logic request_four_flush_ack_n;
  logic host_bridge_request_n;

  // ----------------------------------------------------------------
  // two-way strap pins: device drive, board pull, resolved level
  // ----------------------------------------------------------------
  logic arb_strap_out;
  logic arb_strap_oe;
  logic arb_strap_pull;
  logic arb_strap_level;
  logic fifth_strap_out;
  logic fifth_strap_oe;
  logic fifth_strap_pull;
  logic fifth_strap_level;
  logic mode_strap_out;
  logic mode_strap_oe;
  logic mode_strap_pull;
  logic mode_strap_level;

  // a driving device beats the weak board resistor
  assign arb_strap_level   = arb_strap_oe ? arb_strap_out : arb_strap_pull;
  assign fifth_strap_level = fifth_strap_oe ? fifth_strap_out : fifth_strap_pull;
  assign mode_strap_level  = mode_strap_oe ? mode_strap_out : mode_strap_pull;

  modport dev
  (
    output grant_out_zero_n,
    input  request_in_zero_n,
    output grant_out_one_n,
    input  request_in_one_n,
    input  request_in_two_n,
    input  request_in_three_n,
    output grant_four_flush_req_n,
    input  request_four_flush_ack_n,
    input  host_bridge_request_n,
    output arb_strap_out,
    output arb_strap_oe,
    input  arb_strap_level,
    output fifth_strap_out,
    output fifth_strap_oe,
    input  fifth_strap_level,
    output mode_strap_out,
    output mode_strap_oe,
    input  mode_strap_level
  );

  modport far
  (
    input  grant_out_zero_n,
    output request_in_zero_n,
    input  grant_out_one_n,
    output request_in_one_n,
    output request_in_two_n,
    output request_in_three_n,
    input  grant_four_flush_req_n,
    output request_four_flush_ack_n,
    output host_bridge_request_n,
    output arb_strap_pull,
    input  arb_strap_level,
    output fifth_strap_pull,
    input  fifth_strap_level,
    output mode_strap_pull,
    input  mode_strap_level
  );

endinterface
`default_nettype wire

/* design/pas_far_end.sv */
// board-side parties: strap resistors, external masters and external arbiter
`timescale 1ns/10ps
`default_nettype none
module pas_far_end
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // link
  pas_link_if.far         link,
  // strap settings, 1 = pulled high
  input  wire logic       strap_arb_pull,
  input  wire logic       strap_fifth_pull,
  input  wire logic       strap_mode_pull,
  // external masters, index 5 is the host bridge
  input  wire logic [5:0] master_req,
  output logic      [5:0] master_gnt,
  // external arbiter view of the device functions
  output logic            bridge_granted,
  output logic            disk_granted,
  output logic            flush_seen
);
  import pas_pkg::*;

  // ----------------------------------------------------------------
  // mode as seen by the board
  // ----------------------------------------------------------------
  logic             arb_on;
  logic             fifth_on;
  pas_ext_state_t   ext;
  pas_ext_state_t   next_ext;
  logic             ack_q;
  wire logic        bridge_wants = ~link.grant_out_zero_n;
  wire logic        disk_wants   = ~link.grant_out_one_n;
  wire logic        flush_wants  = ~link.grant_four_flush_req_n;

  assign arb_on   = strap_arb_pull != PAS_STRAP_ARB_DISABLED;
  assign fifth_on = arb_on && (strap_fifth_pull == PAS_STRAP_FIFTH_GRANT);

  assign link.arb_strap_pull   = strap_arb_pull;
  assign link.fifth_strap_pull = strap_fifth_pull;
  assign link.mode_strap_pull  = strap_mode_pull;

  // ----------------------------------------------------------------
  // request pins
  // ----------------------------------------------------------------
  assign link.request_in_zero_n  = arb_on ? ~master_req[0] : ~(ext == PAS_EXT_BRIDGE);
  assign link.request_in_one_n   = arb_on ? ~master_req[1] : ~(ext == PAS_EXT_DISK);
  assign link.request_in_two_n   = ~(arb_on && master_req[2]);
  assign link.request_in_three_n = ~(arb_on && master_req[3]);
  assign link.host_bridge_request_n = ~(arb_on && master_req[5]);
  assign link.request_four_flush_ack_n = fifth_on ? ~master_req[4] : ~ack_q;

  // ----------------------------------------------------------------
  // external arbiter for the two device functions
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ext = ext;
    case (ext)
      PAS_EXT_IDLE:
      begin
        if (!arb_on && bridge_wants)
          next_ext = PAS_EXT_BRIDGE;
        else if (!arb_on && disk_wants)
          next_ext = PAS_EXT_DISK;
      end
      PAS_EXT_BRIDGE:
        if (!bridge_wants)
          next_ext = PAS_EXT_GAP;
      PAS_EXT_DISK:
        if (!disk_wants)
          next_ext = PAS_EXT_GAP;
      PAS_EXT_GAP:
        next_ext = PAS_EXT_IDLE;
      default:
        next_ext = PAS_EXT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ext            <= PAS_EXT_IDLE;
      ack_q          <= 1'b0;
      master_gnt     <= PAS_GNT_RESET;
      bridge_granted <= 1'b0;
      disk_granted   <= 1'b0;
      flush_seen     <= 1'b0;
    end
    else
    begin
      ext            <= next_ext;
      ack_q          <= !fifth_on && flush_wants;
      master_gnt     <= {~link.mode_strap_level, ~link.grant_four_flush_req_n,
                         ~link.fifth_strap_level, ~link.arb_strap_level,
                         ~link.grant_out_one_n, ~link.grant_out_zero_n} &
                        {arb_on, fifth_on, arb_on, arb_on, arb_on, arb_on};
      bridge_granted <= ext == PAS_EXT_BRIDGE;
      disk_granted   <= ext == PAS_EXT_DISK;
      flush_seen     <= !fifth_on && flush_wants;
    end
  end

endmodule
`default_nettype wire

/* design/pas_arbiter.sv */
// on-chip bus arbiter with power-up straps and dual-use request/grant pins
// How it works
// - low arbiter strap at power-up disables arbiter
// - disabled: grant-0 pin carries bridge bus request
// - disabled: request-0 pin is the bridge grant
// - disabled: grant-1 pin carries disk master request
// - disabled: request-1 pin is disk master grant
// - enabled: pins zero are normal grant/request
// - enabled: arbiter strap pin drives grant two
// - enabled: external master asserts request two
// - enabled: fifth strap pin drives grant three
// - fifth strap low: pair is grant/request four
// - fifth strap high: pair is flush request/ack
// - disabled arbiter: pair always flush request/ack
// - flush request driven, far end acknowledges
// - mode strap sampled after power-good rise
// - enabled: mode strap pin drives host grant
// - enabled: host bridge asserts its request
`timescale 1ns/10ps
`default_nettype none
module pas_arbiter
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       power_good,
  // link
  pas_link_if.dev         link,
  // internal bridge and disk master, used with the arbiter disabled
  input  wire logic       bridge_req,
  output logic            bridge_gnt,
  input  wire logic       disk_req,
  output logic            disk_gnt,
  // buffer flush handshake
  input  wire logic       flush_start,
  output logic            flush_busy,
  output logic            flush_done,
  // latched straps and arbiter state
  output logic            straps_valid,
  output logic            arbiter_enabled,
  output logic            fifth_grant_mode,
  output logic            big_endian_mode,
  output logic [5:0]      grant_vector
);
  import pas_pkg::*;

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic pg_q;
  logic arb_strap;
  logic fifth_strap;
  logic mode_strap;
  wire logic pg_rise = power_good && !pg_q;

  // after reset the straps wait for power-good; a second rise is ignored
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pg_q         <= 1'b0;
      straps_valid <= 1'b0;
      arb_strap    <= PAS_STRAP_RESET;
      fifth_strap  <= PAS_STRAP_RESET;
      mode_strap   <= PAS_STRAP_RESET;
    end
    else
    begin
      pg_q <= power_good;
      if (pg_rise && !straps_valid)
      begin
        straps_valid <= 1'b1;
        arb_strap    <= link.arb_strap_level;
        fifth_strap  <= link.fifth_strap_level;
        mode_strap   <= link.mode_strap_level;
      end
    end
  end

  wire logic arb_on   = straps_valid && (arb_strap != PAS_STRAP_ARB_DISABLED);
  wire logic arb_off  = straps_valid && !arb_on;
  // the arbiter-disable strap overrides the fifth-master strap
  wire logic fifth_on = arb_on && (fifth_strap == PAS_STRAP_FIFTH_GRANT);
  wire logic flush_on = straps_valid && !fifth_on;

  assign arbiter_enabled  = arb_on;
  assign fifth_grant_mode = fifth_on;
  assign big_endian_mode  = straps_valid && (mode_strap == PAS_STRAP_MODE_BIG_END);

  // ----------------------------------------------------------------
  // request vector, index 5 is the host bridge
  // ----------------------------------------------------------------
  logic [5:0] req;
  assign req[0] = arb_on && !link.request_in_zero_n;
  assign req[1] = arb_on && !link.request_in_one_n;
  assign req[2] = arb_on && !link.request_in_two_n;
  assign req[3] = arb_on && !link.request_in_three_n;
  assign req[4] = fifth_on && !link.request_four_flush_ack_n;
  assign req[5] = arb_on && !link.host_bridge_request_n;

  // round robin, starting after the last owner so no master starves
  function automatic logic [2:0] pas_pick(input logic [5:0] r, input logic [2:0] last);
    logic [2:0] pick;
    logic       found;
    int         idx;
    pick  = last;
    found = 1'b0;
    for (int i = 1; i <= PAS_MASTERS; i++)
    begin
      idx = (int'(last) + i) % PAS_MASTERS;
      if (!found && r[idx])
      begin
        pick  = 3'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // ----------------------------------------------------------------
  // arbiter state machine
  // ----------------------------------------------------------------
  pas_arb_state_t arb;
  pas_arb_state_t next_arb;
  logic [2:0]     owner;
  logic [2:0]     next_owner;
  logic [5:0]     next_gnt;
  wire logic [2:0] picked = pas_pick(req, owner);

  always_comb
  begin
    next_arb   = arb;
    next_owner = owner;
    case (arb)
      PAS_ARB_IDLE:
      begin
        if (|req)
        begin
          next_arb   = PAS_ARB_GRANT;
          next_owner = picked;
        end
      end
      PAS_ARB_GRANT:
        if (!req[owner])
          next_arb = PAS_ARB_GAP;
      // gap, then idle: two dead cycles so two grants never overlap on the pins
      PAS_ARB_GAP:
        next_arb = PAS_ARB_IDLE;
      default:
        next_arb = PAS_ARB_IDLE;
    endcase
  end

  assign next_gnt = (next_arb == PAS_ARB_GRANT) ? 6'(6'h01 << next_owner)
                                                : PAS_GNT_RESET;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      arb          <= PAS_ARB_IDLE;
      owner        <= PAS_OWNER_RESET;
      grant_vector <= PAS_GNT_RESET;
    end
    else
    begin
      arb          <= next_arb;
      owner        <= next_owner;
      grant_vector <= next_gnt;
    end
  end

  // ----------------------------------------------------------------
  // buffer flush handshake
  // ----------------------------------------------------------------
  pas_flush_state_t fl;
  pas_flush_state_t next_fl;
  wire logic ack_low = !link.request_four_flush_ack_n;

  always_comb
  begin
    next_fl = fl;
    case (fl)
      PAS_FL_IDLE:
        if (flush_on && flush_start)
          next_fl = PAS_FL_REQ;
      PAS_FL_REQ:
        if (ack_low)
          next_fl = PAS_FL_RELEASE;
      PAS_FL_RELEASE:
        if (!ack_low)
          next_fl = PAS_FL_IDLE;
      default:
        next_fl = PAS_FL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fl         <= PAS_FL_IDLE;
      flush_done <= 1'b0;
    end
    else
    begin
      fl         <= next_fl;
      flush_done <= (fl == PAS_FL_RELEASE) && !ack_low;
    end
  end

  assign flush_busy = fl != PAS_FL_IDLE;

  // ----------------------------------------------------------------
  // pin multiplexing, all pins registered
  // ----------------------------------------------------------------
  logic next_grant_out_zero_n;
  logic next_grant_out_one_n;
  logic next_pair_n;
  logic next_strap_oe;

  assign next_grant_out_zero_n   = arb_on ? !next_gnt[PAS_IDX_ZERO]
                                : !(arb_off && bridge_req);
  assign next_grant_out_one_n   = arb_on ? !next_gnt[PAS_IDX_ONE] : !(arb_off && disk_req);
  assign next_pair_n   = fifth_on ? !next_gnt[PAS_IDX_FOUR]
                                  : !(next_fl == PAS_FL_REQ);
  // strap pins stay undriven until sampled, so the resistors are read cleanly
  assign next_strap_oe = arb_on;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      link.grant_out_zero_n       <= PAS_PIN_IDLE;
      link.grant_out_one_n        <= PAS_PIN_IDLE;
      link.grant_four_flush_req_n <= PAS_PIN_IDLE;
      link.arb_strap_out          <= PAS_PIN_IDLE;
      link.fifth_strap_out        <= PAS_PIN_IDLE;
      link.mode_strap_out         <= PAS_PIN_IDLE;
      link.arb_strap_oe           <= PAS_OE_RESET;
      link.fifth_strap_oe         <= PAS_OE_RESET;
      link.mode_strap_oe          <= PAS_OE_RESET;
      bridge_gnt                  <= 1'b0;
      disk_gnt                    <= 1'b0;
    end
    else
    begin
      link.grant_out_zero_n       <= next_grant_out_zero_n;
      link.grant_out_one_n        <= next_grant_out_one_n;
      link.grant_four_flush_req_n <= next_pair_n;
      link.arb_strap_out          <= !next_gnt[PAS_IDX_TWO];
      link.fifth_strap_out        <= !next_gnt[PAS_IDX_THREE];
      link.mode_strap_out         <= !next_gnt[PAS_IDX_HOST];
      link.arb_strap_oe           <= next_strap_oe;
      link.fifth_strap_oe         <= next_strap_oe;
      link.mode_strap_oe          <= next_strap_oe;
      bridge_gnt                  <= arb_off && !link.request_in_zero_n;
      disk_gnt                    <= arb_off && !link.request_in_one_n;
    end
  end

endmodule
`default_nettype wire

/* verification/pas_link_assertions.sv */
// concurrent checks on the pins between the arbiter device and the board
`timescale 1ns/10ps
`default_nettype none
module pas_link_assertions
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // plain pins
  input wire logic grant_out_zero_n,
  input wire logic request_in_zero_n,
  input wire logic grant_out_one_n,
  input wire logic request_in_two_n,
  input wire logic request_in_three_n,
  input wire logic grant_four_flush_req_n,
  input wire logic request_four_flush_ack_n,
  input wire logic host_bridge_request_n,
  // strap pins
  input wire logic arb_strap_out,
  input wire logic arb_strap_oe,
  input wire logic arb_strap_pull,
  input wire logic fifth_strap_out,
  input wire logic fifth_strap_oe,
  input wire logic fifth_strap_pull,
  input wire logic mode_strap_out,
  input wire logic mode_strap_oe
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // the shared pair is a grant only if the fifth strap was low when latched
  logic [1:0] fifth_hist;
  logic       fifth_oe_q;
  logic       four_mode;
  logic [5:0] gnt_low;

  assign gnt_low = {~grant_out_zero_n, ~grant_out_one_n, arb_strap_oe & ~arb_strap_out,
                    fifth_strap_oe & ~fifth_strap_out, mode_strap_oe & ~mode_strap_out,
                    four_mode & ~grant_four_flush_req_n};

  always_ff @(posedge sys_clk)
  begin
    fifth_hist <= {fifth_hist[0], fifth_strap_pull};
    fifth_oe_q <= fifth_strap_oe;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      four_mode <= 1'b0;
    else if (fifth_strap_oe && !fifth_oe_q)
      four_mode <= !fifth_hist[1];
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence flush_acked;
    !four_mode && !grant_four_flush_req_n && !request_four_flush_ack_n;
  endsequence

  sequence grants_dropped;
    arb_strap_oe && $rose(~|gnt_low);
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_grant_one_hot: assert property (arb_strap_oe |-> $onehot0(gnt_low))
    else $error("more than one grant pin low");
  chk_grant_gap: assert property (grants_dropped |=> ~|gnt_low)
    else $error("grant issued without an idle gap");
  chk_zero_cause: assert property (arb_strap_oe && $fell(grant_out_zero_n) |->
    !$past(request_in_zero_n)) else $error("grant zero without request zero");
  chk_two_release: assert property (arb_strap_oe && !arb_strap_out && request_in_two_n
    |=> arb_strap_out) else $error("grant two held after request two dropped");
  chk_three_cause: assert property (fifth_strap_oe && $fell(fifth_strap_out) |->
    !$past(request_in_three_n)) else $error("grant three without request three");
  chk_host_cause: assert property (mode_strap_oe && $fell(mode_strap_out) |->
    !$past(host_bridge_request_n)) else $error("host grant without host request");
  chk_four_cause: assert property (four_mode && $fell(grant_four_flush_req_n) |->
    !$past(request_four_flush_ack_n)) else $error("grant four without request four");
  chk_flush_release: assert property (flush_acked |=> grant_four_flush_req_n)
    else $error("flush request held after acknowledge");
  chk_strap_latch: assert property ($rose(arb_strap_oe) |-> $past(arb_strap_pull, 2)
    && fifth_strap_oe && mode_strap_oe) else $error("strap pins driven while disabled");
  chk_strap_held: assert property (arb_strap_oe |=> arb_strap_oe && mode_strap_oe)
    else $error("strap pin drive changed after latching");
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench joining the arbiter device and its board-side parties
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pas_pkg::*;
  logic       sys_clk         = 1'b0;
  logic       reset           = 1'b1;
  logic       power_good      = 1'b0;
  logic       bridge_req      = 1'b0;
  logic       disk_req        = 1'b0;
  logic       flush_start     = 1'b0;
  logic       pull_arb        = 1'b1;
  logic       pull_fifth      = 1'b1;
  logic       pull_mode       = 1'b1;
  logic [5:0] master_req      = 6'h00;
  logic [5:0] master_gnt;
  logic [5:0] grant_vector;
  logic       bridge_gnt;
  logic       disk_gnt;
  logic       bridge_granted;
  logic       disk_granted;
  logic       flush_seen;
  logic       flush_busy;
  logic       flush_done;
  logic       straps_valid;
  logic       arbiter_enabled;
  logic       fifth_grant_mode;
  logic       big_endian_mode;
  int         n_fail          = 0;
  int         samples_checked = 0;

  // ----------------------------------------------------------------
  // clock, parts and checker
  // ----------------------------------------------------------------
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  pas_link_if pas_link_if_i ();

  pas_arbiter pas_arbiter_i (.sys_clk(sys_clk), .reset(reset), .power_good(power_good),
    .link(pas_link_if_i), .bridge_req(bridge_req), .bridge_gnt(bridge_gnt),
    .disk_req(disk_req), .disk_gnt(disk_gnt), .flush_start(flush_start),
    .flush_busy(flush_busy), .flush_done(flush_done), .straps_valid(straps_valid),
    .arbiter_enabled(arbiter_enabled), .fifth_grant_mode(fifth_grant_mode),
    .big_endian_mode(big_endian_mode), .grant_vector(grant_vector));

  pas_far_end pas_far_end_i (.sys_clk(sys_clk), .reset(reset), .link(pas_link_if_i),
    .strap_arb_pull(pull_arb), .strap_fifth_pull(pull_fifth), .strap_mode_pull(pull_mode),
    .master_req(master_req), .master_gnt(master_gnt), .bridge_granted(bridge_granted),
    .disk_granted(disk_granted), .flush_seen(flush_seen));

  pas_link_assertions pas_link_assertions_i (.sys_clk(sys_clk), .reset(reset),
    .grant_out_zero_n(pas_link_if_i.grant_out_zero_n),
    .request_in_zero_n(pas_link_if_i.request_in_zero_n),
    .grant_out_one_n(pas_link_if_i.grant_out_one_n),
    .request_in_two_n(pas_link_if_i.request_in_two_n),
    .request_in_three_n(pas_link_if_i.request_in_three_n),
    .grant_four_flush_req_n(pas_link_if_i.grant_four_flush_req_n),
    .request_four_flush_ack_n(pas_link_if_i.request_four_flush_ack_n),
    .host_bridge_request_n(pas_link_if_i.host_bridge_request_n),
    .arb_strap_out(pas_link_if_i.arb_strap_out), .arb_strap_oe(pas_link_if_i.arb_strap_oe),
    .arb_strap_pull(pas_link_if_i.arb_strap_pull),
    .fifth_strap_out(pas_link_if_i.fifth_strap_out),
    .fifth_strap_oe(pas_link_if_i.fifth_strap_oe),
    .fifth_strap_pull(pas_link_if_i.fifth_strap_pull),
    .mode_strap_out(pas_link_if_i.mode_strap_out), .mode_strap_oe(pas_link_if_i.mode_strap_oe));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_straps(input logic a, input logic f, input logic m);
    chk("straps valid", 8'h01, 8'(straps_valid));
    chk("arbiter enabled", 8'(a), 8'(arbiter_enabled));
    chk("fifth grant mode", 8'(a & ~f), 8'(fifth_grant_mode));
    chk("big endian mode", 8'(m), 8'(big_endian_mode));
  endtask

  // resets, latches straps, then moves the pulls to show they are ignored
  task automatic power_up(input logic a, input logic f, input logic m);
    @(negedge sys_clk);
    reset = 1'b1;
    power_good = 1'b0;
    pull_arb = a;
    pull_fifth = f;
    pull_mode = m;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    power_good = 1'b1;
    repeat (3) @(negedge sys_clk);
    check_straps(a, f, m);
    power_good = 1'b0;
    pull_arb = ~a;
    pull_fifth = ~f;
    pull_mode = ~m;
    @(negedge sys_clk);
    power_good = 1'b1;
    repeat (3) @(negedge sys_clk);
    check_straps(a, f, m);
    pull_arb = a;
    pull_fifth = f;
    pull_mode = m;
  endtask

  // all six ask at once: grants come one at a time in round-robin order
  task automatic grant_round;
    int i;
    @(negedge sys_clk);
    master_req = 6'h3f;
    for (i = 0; i < 6; i++)
    begin
      repeat (10) if (grant_vector === 6'h00) @(negedge sys_clk);
      chk("grant vector", 8'(6'h01 << i), 8'(grant_vector));
      @(negedge sys_clk);
      chk("far end grant", 8'(6'h01 << i), 8'(master_gnt));
      master_req[i] = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("grant released", 8'h00, 8'(grant_vector));
    end
  endtask

  task automatic flush_run;
    @(negedge sys_clk);
    flush_start = 1'b1;
    @(negedge sys_clk);
    flush_start = 1'b0;
    chk("flush busy", 8'h01, 8'(flush_busy));
    chk("flush pin", 8'h00, 8'(pas_link_if_i.grant_four_flush_req_n));
    @(negedge sys_clk);
    chk("far end flush seen", 8'h01, 8'(flush_seen));
    repeat (10) if (flush_done !== 1'b1) @(negedge sys_clk);
    chk("flush done", 8'h01, 8'(flush_done));
  endtask

  // arbiter off: own masters request outward, other requests are ignored
  task automatic pass_through;
    @(negedge sys_clk);
    bridge_req = 1'b1;
    disk_req = 1'b1;
    master_req = 6'h2c;
    repeat (10) if (bridge_gnt !== 1'b1) @(negedge sys_clk);
    chk("bridge grant", 8'h01, 8'(bridge_gnt));
    chk("far arbiter grant", 8'h01, 8'(bridge_granted));
    chk("bridge request pin", 8'h00, 8'(pas_link_if_i.grant_out_zero_n));
    chk("disk request pin", 8'h00, 8'(pas_link_if_i.grant_out_one_n));
    chk("grant vector off", 8'h00, 8'(grant_vector));
    chk("strap pin undriven", 8'h00, 8'(pas_link_if_i.arb_strap_oe));
    bridge_req = 1'b0;
    repeat (10) if (disk_gnt !== 1'b1) @(negedge sys_clk);
    chk("disk grant", 8'h01, 8'(disk_gnt));
    chk("far arbiter disk grant", 8'h01, 8'(disk_granted));
    disk_req = 1'b0;
    master_req = 6'h00;
    repeat (4) @(negedge sys_clk);
    chk("disk grant gone", 8'h00, 8'(disk_gnt));
  endtask

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    power_up(1'b1, 1'b1, 1'b1);
    flush_run();
    power_up(1'b1, 1'b0, 1'b0);
    grant_round();
    power_up(1'b0, 1'b0, 1'b1);
    pass_through();
    flush_run();
    stop_test();
  end

  // the whole sequence needs fewer than two hundred cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
